// >>> shared/tpc_regs.svh
// Register offsets, field positions, reset values for the timer channel
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH
`define TPC_OFF_CHAN_SC   8'h00
`define TPC_OFF_VAL_HIGH  8'h01
`define TPC_OFF_VAL_LOW   8'h02
`define TPC_OFF_GLB_CTRL  8'h03
`define TPC_OFF_IRQ_STAT  8'h04
`define TPC_OFF_IRQ_CLR   8'h05
`define TPC_OFF_IRQ_EN    8'h06
`define TPC_SC_FLAG       7
`define TPC_SC_IE         6
`define TPC_SC_MSH        5
`define TPC_SC_MSL        4
`define TPC_SC_ELSH       3
`define TPC_SC_ELSL       2
`define TPC_GLB_CAS       0
`define TPC_IRQ_EVT       0
`define TPC_CTL_RESET     5'h00
`define TPC_VAL_RESET     16'h0000
`define TPC_FREE_MOD      16'hFFFF
`endif

// >>> shared/tpc_pkg.sv
// Types for the timer channel mode control block
package tpc_pkg;
   typedef enum logic [1:0] {
      TPC_MD_CAPTURE = 2'b00,
      TPC_MD_COMPARE = 2'b01,
      TPC_MD_EPWM    = 2'b10,
      TPC_MD_CPWM    = 2'b11
   } tpc_mode_t;
   typedef logic [7:0]  tpc_byte_t;
   typedef logic [15:0] tpc_word_t;
endpackage

// >>> core/tpc_channel.sv
// Timer channel status, control, value register and pin logic
`timescale 1ns/1ps
`include "tpc_regs.svh"

module tpc_channel (
   input  wire logic               MCLK_I,
   input  wire logic               RST_B_I,
   input  wire logic [7:0]         ADDR_I,
   input  wire tpc_pkg::tpc_byte_t WDATA_I,
   input  wire logic               WR_I,
   input  wire logic               RD_I,
   output tpc_pkg::tpc_byte_t      RDATA_O,
   input  wire tpc_pkg::tpc_word_t CNT_I,
   input  wire tpc_pkg::tpc_word_t MOD_I,
   input  wire logic               CNT_TICK_I,
   input  wire logic               CNT_RUN_I,
   input  wire logic               CNT_DOWN_I,
   input  wire logic               DBG_HALT_I,
   input  wire logic               PIN_I,
   output logic                    PIN_O,
   output logic                    PIN_OE_O,
   output logic                    PIN_RELEASE_O,
   output logic                    COUNT_UPDOWN_O,
   output logic                    CH_IRQ_O,
   output logic                    IRQ_O
);
   import tpc_pkg::*;

   logic        flag;
   logic        armed;
   logic [4:0]  ctl;
   logic        cas;
   tpc_word_t   val;
   tpc_byte_t   wbuf_hi;
   tpc_byte_t   wbuf_lo;
   logic        wpend_hi;
   logic        wpend_lo;
   tpc_word_t   rbuf;
   logic        rlatched;
   logic        rlat_hi;
   logic        pin_q;
   logic        ev_stat;
   logic        ev_en;
   tpc_mode_t   mode;
   logic [1:0]  els;
   logic        pin_used;
   logic        rise;
   logic        fall;
   logic        cap_evt;
   logic        match;
   logic        pwm_mode;
   logic        duty0;
   logic        duty100;
   logic        cmp_evt;
   logic        chan_evt;
   logic        act;
   tpc_word_t   mod_eff;
   logic        sc_wr;
   logic        sc_rd;
   logic        vh_wr;
   logic        vl_wr;
   logic        vh_rd;
   logic        vl_rd;
   logic        xfer;
   tpc_byte_t   next_rdata;

   assign sc_wr = WR_I && (ADDR_I == `TPC_OFF_CHAN_SC);
   assign sc_rd = RD_I && (ADDR_I == `TPC_OFF_CHAN_SC);
   assign vh_wr = WR_I && (ADDR_I == `TPC_OFF_VAL_HIGH);
   assign vl_wr = WR_I && (ADDR_I == `TPC_OFF_VAL_LOW);
   assign vh_rd = RD_I && (ADDR_I == `TPC_OFF_VAL_HIGH);
   assign vl_rd = RD_I && (ADDR_I == `TPC_OFF_VAL_LOW);

   always_comb begin
      if (cas) begin
         mode = TPC_MD_CPWM;
      end else if (ctl[`TPC_SC_MSH - 2]) begin
         mode = TPC_MD_EPWM;
      end else if (ctl[`TPC_SC_MSL - 2]) begin
         mode = TPC_MD_COMPARE;
      end else begin
         mode = TPC_MD_CAPTURE;
      end
   end

   assign els      = ctl[`TPC_SC_ELSH - 2 : `TPC_SC_ELSL - 2];
   assign pin_used = (els != 2'b00);
   assign act      = ~els[0];
   // Modulo zero means free running
   assign mod_eff  = (MOD_I == 16'h0000) ? `TPC_FREE_MOD : MOD_I;

   assign rise    = PIN_I & ~pin_q;
   assign fall    = ~PIN_I & pin_q;
   assign cap_evt = (mode == TPC_MD_CAPTURE) && pin_used
                    && ((els[0] && rise) || (els[1] && fall));

   assign match    = CNT_TICK_I && (CNT_I == val);
   assign pwm_mode = (mode == TPC_MD_EPWM) || (mode == TPC_MD_CPWM);
   assign duty0    = (val == 16'h0000);
   assign duty100  = (val > mod_eff);
   assign cmp_evt  = (mode != TPC_MD_CAPTURE) && match
                     && !(pwm_mode && (duty0 || duty100));
   assign chan_evt = cap_evt || cmp_evt;

   // Previous pin level for edge detect
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= PIN_I;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         armed <= 1'b0;
      end else if (chan_evt) begin
         armed <= 1'b0;
      end else if (sc_rd && flag) begin
         armed <= 1'b1;
      end else if (sc_wr) begin
         armed <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         flag <= 1'b0;
      end else if (chan_evt) begin
         flag <= 1'b1;
      end else if (sc_wr && armed && !WDATA_I[`TPC_SC_FLAG]) begin
         flag <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         ctl <= `TPC_CTL_RESET;
      end else if (sc_wr) begin
         ctl <= WDATA_I[`TPC_SC_IE:`TPC_SC_ELSL];
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         cas            <= 1'b0;
         COUNT_UPDOWN_O <= 1'b0;
      end else if (WR_I && (ADDR_I == `TPC_OFF_GLB_CTRL)) begin
         cas            <= WDATA_I[`TPC_GLB_CAS];
         COUNT_UPDOWN_O <= WDATA_I[`TPC_GLB_CAS];
      end
   end

   // Buffered pair moves at the documented moment
   assign xfer = wpend_hi && wpend_lo && (!CNT_RUN_I
                 || ((mode == TPC_MD_COMPARE) && CNT_TICK_I)
                 || (pwm_mode && CNT_TICK_I && (CNT_I == mod_eff)));

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         val <= `TPC_VAL_RESET;
      end else if (cap_evt) begin
         val <= CNT_I;
      end else if (mode != TPC_MD_CAPTURE) begin
         if (DBG_HALT_I && vh_wr) begin
            val[15:8] <= WDATA_I;
         end else if (DBG_HALT_I && vl_wr) begin
            val[7:0] <= WDATA_I;
         end else if (xfer) begin
            val <= {wbuf_hi, wbuf_lo};
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         wbuf_hi  <= 8'h00;
         wbuf_lo  <= 8'h00;
         wpend_hi <= 1'b0;
         wpend_lo <= 1'b0;
      end else if (sc_wr || (xfer && !DBG_HALT_I)) begin
         wpend_hi <= 1'b0;
         wpend_lo <= 1'b0;
      end else if (!DBG_HALT_I && (mode != TPC_MD_CAPTURE)) begin
         if (vh_wr) begin
            wbuf_hi  <= WDATA_I;
            wpend_hi <= 1'b1;
         end
         if (vl_wr) begin
            wbuf_lo  <= WDATA_I;
            wpend_lo <= 1'b1;
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         rbuf     <= 16'h0000;
         rlatched <= 1'b0;
         rlat_hi  <= 1'b0;
      end else if (sc_wr) begin
         rlatched <= 1'b0;
      end else if (!DBG_HALT_I && (mode == TPC_MD_CAPTURE)) begin
         if (!rlatched && (vh_rd || vl_rd)) begin
            rbuf     <= val;
            rlatched <= 1'b1;
            rlat_hi  <= vh_rd;
         end else if ((rlat_hi && vl_rd) || (!rlat_hi && vh_rd)) begin
            rlatched <= 1'b0;
         end
      end
   end

   // Read mux, unmapped reads as zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (ADDR_I)
         `TPC_OFF_CHAN_SC:  next_rdata = {flag, ctl, 2'b00};
         `TPC_OFF_VAL_HIGH: next_rdata = (rlatched && !DBG_HALT_I) ? rbuf[15:8] : val[15:8];
         `TPC_OFF_VAL_LOW:  next_rdata = (rlatched && !DBG_HALT_I) ? rbuf[7:0] : val[7:0];
         `TPC_OFF_GLB_CTRL: next_rdata = {7'h00, cas};
         `TPC_OFF_IRQ_STAT: next_rdata = {7'h00, ev_stat};
         `TPC_OFF_IRQ_EN:   next_rdata = {7'h00, ev_en};
         default:           next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         RDATA_O <= 8'h00;
      end else if (RD_I) begin
         RDATA_O <= next_rdata;
      end else begin
         RDATA_O <= 8'h00;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         PIN_O <= 1'b0;
      end else if (mode == TPC_MD_COMPARE) begin
         if (match) begin
            unique case (els)
               2'b01:   PIN_O <= ~PIN_O;
               2'b10:   PIN_O <= 1'b0;
               2'b11:   PIN_O <= 1'b1;
               default: PIN_O <= PIN_O;
            endcase
         end
      end else if (pwm_mode) begin
         if (duty0) begin
            PIN_O <= ~act;
         end else if (duty100) begin
            PIN_O <= act;
         end else if (mode == TPC_MD_EPWM) begin
            if (match) begin
               PIN_O <= ~act;
            end else if (CNT_TICK_I && (CNT_I == 16'h0000)) begin
               PIN_O <= act;
            end
         end else if (match) begin
            PIN_O <= CNT_DOWN_I ? act : ~act;
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         PIN_OE_O      <= 1'b0;
         PIN_RELEASE_O <= 1'b1;
      end else begin
         PIN_OE_O      <= pin_used && (mode != TPC_MD_CAPTURE);
         PIN_RELEASE_O <= !pin_used;
      end
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         ev_stat <= 1'b0;
         ev_en   <= 1'b0;
      end else begin
         if (chan_evt) begin
            ev_stat <= 1'b1;
         end else if (WR_I && (ADDR_I == `TPC_OFF_IRQ_CLR) && WDATA_I[`TPC_IRQ_EVT]) begin
            ev_stat <= 1'b0;
         end
         if (WR_I && (ADDR_I == `TPC_OFF_IRQ_EN)) begin
            ev_en <= WDATA_I[`TPC_IRQ_EVT];
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_B_I) begin
         CH_IRQ_O <= 1'b0;
         IRQ_O    <= 1'b0;
      end else begin
         CH_IRQ_O <= flag && ctl[`TPC_SC_IE - 2];
         IRQ_O    <= ev_stat && ev_en;
      end
   end

   property p_evt_sets_flag;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      chan_evt |=> flag;
   endproperty
   a_evt_sets_flag: assert property (p_evt_sets_flag) else $error("event lost");
   property p_clear_needs_arm;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (flag && !armed) |=> flag;
   endproperty
   a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("flag cleared unarmed");
   property p_clear_seq;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (sc_rd && flag && !chan_evt) ##1 (sc_wr && !WDATA_I[7] && !chan_evt) |=> !flag;
   endproperty
   a_clear_seq: assert property (p_clear_seq) else $error("clear sequence failed");
   property p_write_one;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (!flag && !chan_evt) |=> !flag;
   endproperty
   a_write_one: assert property (p_write_one) else $error("flag set without event");
   property p_ch_irq;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (flag && ctl[4]) |=> CH_IRQ_O;
   endproperty
   a_ch_irq: assert property (p_ch_irq) else $error("channel irq missing");
   property p_no_irq_disabled;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      !ctl[4] |=> !CH_IRQ_O;
   endproperty
   a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while disabled");
   property p_pwm_extreme;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (pwm_mode && ((val == 16'h0000) || (val > mod_eff)) && !flag) |=> !flag;
   endproperty
   a_pwm_extreme: assert property (p_pwm_extreme) else $error("pwm extreme event");

   property p_release;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      (els == 2'b00) |=> (!PIN_OE_O && PIN_RELEASE_O);
   endproperty
   a_release: assert property (p_release) else $error("pin not released");

   property p_capture_val;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      cap_evt |=> (val == $past(CNT_I));
   endproperty
   a_capture_val: assert property (p_capture_val) else $error("capture value wrong");

   property p_oc_set;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      ((mode == TPC_MD_COMPARE) && match && (els == 2'b11)) |=> PIN_O;
   endproperty
   a_oc_set: assert property (p_oc_set) else $error("set on compare failed");

   property p_sc_unlatch;
      @(posedge MCLK_I) disable iff (!RST_B_I)
      sc_wr |=> (!rlatched && !wpend_hi && !wpend_lo);
   endproperty
   a_sc_unlatch: assert property (p_sc_unlatch) else $error("latch not reset");

endmodule // tpc_channel

// >>> tb/tpc_pin_model.sv
// External circuit model on the timer channel pin
`timescale 1ns/1ps
module tpc_pin_model (
   input  wire logic clk_i,
   input  wire logic ext_lvl_i,
   input  wire logic pin_o_i,
   input  wire logic pin_oe_i,
   output logic      pin_lvl_o
);
   logic ext_q;
   // level moves only after an edge
   always_ff @(posedge clk_i) begin
      ext_q <= ext_lvl_i;
   end
   // Block drive wins while enabled
   assign pin_lvl_o = pin_oe_i ? pin_o_i : ext_q;
endmodule // tpc_pin_model

// >>> tb/tpc_channel_tb.sv
// Self-checking bench for the timer channel block
`timescale 1ns/1ps
module tpc_channel_tb;
   logic        mclk;
   logic        rst_b;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [15:0] cnt;
   logic [15:0] mod_v;
   logic        tick;
   logic        down;
   logic        halt;
   logic        ext;
   logic        pin_in;
   logic        pin_out;
   logic        pin_oe;
   logic        pin_rel;
   logic        updown;
   logic        ch_irq;
   logic        irq;
   int          mismatches;
   int          n_tests;

   tpc_channel tpc_channel_inst (
      .MCLK_I(mclk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .CNT_I(cnt), .MOD_I(mod_v), .CNT_TICK_I(tick), .CNT_RUN_I(1'b0),
      .CNT_DOWN_I(down), .DBG_HALT_I(halt), .PIN_I(pin_in), .PIN_O(pin_out),
      .PIN_OE_O(pin_oe), .PIN_RELEASE_O(pin_rel), .COUNT_UPDOWN_O(updown),
      .CH_IRQ_O(ch_irq), .IRQ_O(irq)
   );
   tpc_pin_model tpc_pin_model_inst (
      .clk_i(mclk), .ext_lvl_i(ext), .pin_o_i(pin_out), .pin_oe_i(pin_oe),
      .pin_lvl_o(pin_in)
   );

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic close_out();
      $display("Compares %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   // Read then write of the control register with no gap between strobes
   task automatic rdwr(input logic [7:0] e, input logic [7:0] d);
      @(posedge mclk);
      addr <= 8'h00;
      rd   <= 1'b1;
      @(posedge mclk);
      rd    <= 1'b0;
      wr    <= 1'b1;
      wdata <= d;
      #1;
      chk(rdata, e);
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   // Counter step; pin action lands a cycle later
   task automatic tk(input logic [15:0] c, input logic dn);
      @(posedge mclk);
      cnt  <= c;
      down <= dn;
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
      settle();
   endtask

   task automatic pin(input logic v);
      @(posedge mclk);
      ext <= v;
      repeat (4) @(posedge mclk);
   endtask

   task automatic val(input logic [15:0] v);
      wr8(8'h01, v[15:8]);
      wr8(8'h02, v[7:0]);
   endtask

   // Sized for the longest sequence with wide margin
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      close_out();
   end

   initial begin
      mismatches = 0;
      n_tests    = 0;
      rst_b = 1'b0;
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
      cnt   = 16'h1234;
      mod_v = 16'h00FF;
      tick  = 1'b0;
      down  = 1'b0;
      halt  = 1'b0;
      ext   = 1'b0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      rchk(8'h00, 8'h00);
      chk(pin_rel, 1'b1);
      wr8(8'h07, 8'hFF);
      rchk(8'h07, 8'h00);
      wr8(8'h06, 8'h01);
      // Capture on rising edge, pin quiet since reset
      wr8(8'h00, 8'h44);
      pin(1'b1);
      rchk(8'h00, 8'hC4);
      chk(ch_irq, 1'b1);
      chk(irq, 1'b1);
      rchk(8'h01, 8'h12);
      rchk(8'h02, 8'h34);
      rchk(8'h00, 8'hC4);
      pin(1'b0);
      pin(1'b1);
      wr8(8'h00, 8'h44);
      rchk(8'h00, 8'hC4);
      wr8(8'h00, 8'hC4);
      rchk(8'h00, 8'hC4);
      wr8(8'h00, 8'h48);
      rchk(8'h00, 8'h48);
      settle();
      chk(ch_irq, 1'b0);
      @(posedge mclk);
      cnt <= 16'h5678;
      pin(1'b0);
      rdwr(8'hC8, 8'h48);
      pin(1'b1);
      rchk(8'h00, 8'h48);
      wr8(8'h00, 8'h0C);
      pin(1'b0);
      rchk(8'h00, 8'h8C);
      chk(ch_irq, 1'b0);
      // Latched high byte dropped by control write, halted too
      rchk(8'h01, 8'h56);
      @(posedge mclk);
      cnt  <= 16'h9ABC;
      halt <= 1'b1;
      wr8(8'h00, 8'h0C);
      halt <= 1'b0;
      pin(1'b1);
      rchk(8'h02, 8'hBC);
      rchk(8'h04, 8'h01);
      wr8(8'h05, 8'h01);
      rchk(8'h04, 8'h00);
      chk(irq, 1'b0);
      // Compare actions toggle, low, high
      wr8(8'h00, 8'h14);
      val(16'h0010);
      for (int i = 1; i < 4; i++) begin
         wr8(8'h00, {4'h1, 2'(i), 2'b00});
         tk(16'h0010, 1'b0);
         chk(pin_out, (i == 2) ? 1'b0 : 1'b1);
         chk(pin_oe, 1'b1);
      end
      rchk(8'h00, 8'h9C);
      wr8(8'h00, 8'h10);
      settle();
      chk(pin_rel, 1'b1);
      chk(pin_oe, 1'b0);
      // Edge PWM, both polarities; low mode bit ignored
      for (int j = 0; j < 2; j++) begin
         wr8(8'h00, (j == 0) ? 8'h38 : 8'h24);
         tk(16'h0000, 1'b0);
         chk(pin_out, (j == 0) ? 1'b1 : 1'b0);
         tk(16'h0010, 1'b0);
         chk(pin_out, (j == 0) ? 1'b0 : 1'b1);
      end
      rchk(8'h00, 8'hA4);
      wr8(8'h00, 8'h28);
      val(16'h0000);
      tk(16'h0000, 1'b0);
      tk(16'h0010, 1'b0);
      rchk(8'h00, 8'h28);
      chk(pin_out, 1'b0);
      val(16'h0100);
      tk(16'h0100, 1'b0);
      chk(pin_out, 1'b1);
      rchk(8'h00, 8'h28);
      // Center PWM overrides capture mode bits
      wr8(8'h03, 8'h01);
      val(16'h0010);
      wr8(8'h00, 8'h08);
      settle();
      chk(updown, 1'b1);
      tk(16'h0010, 1'b1);
      chk(pin_out, 1'b1);
      tk(16'h0010, 1'b0);
      chk(pin_out, 1'b0);
      chk(pin_oe, 1'b1);
      wr8(8'h03, 8'h00);
      settle();
      chk(updown, 1'b0);
      close_out();
   end
endmodule // tpc_channel_tb
